// ==== rtl/lpg_pkg.sv ====
// constants shared by the flash command interpreter.
// assumes a 100 MHz system clock that oversamples the serial link.

package lpg_pkg;

	// ---------------------------------------------------------------
	// opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_WRITE_ENABLE_CMD      = 8'h06;
	localparam logic [7:0] OP_READ_STATUS           = 8'h05;
	localparam logic [7:0] OP_GANG_UNPROTECT_CMD    = 8'h98;
	localparam logic [7:0] OP_PROGRAM_NV_PATTERN    = 8'h43;
	localparam logic [7:0] OP_WRITE_VOL_PATTERN     = 8'h4A;
	localparam logic [7:0] OP_READ_PATTERN_CMD      = 8'h41;
	localparam logic [7:0] OP_FAST_READ_DR          = 8'h0D;
	localparam logic [7:0] OP_FAST_READ_DUAL_IO_DR  = 8'hBD;
	localparam logic [7:0] OP_FAST_READ_QUAD_IO_DR  = 8'hED;

	// ---------------------------------------------------------------
	// framing and field positions
	// ---------------------------------------------------------------
	localparam logic [5:0] OPCODE_BITS     = 6'h08;
	localparam logic [5:0] CMD_DATA_BITS   = 6'h10;
	localparam logic [5:0] BITCNT_CAP      = 6'h20;
	localparam int         ADDR_BITS       = 24;
	localparam int         MODE_BITS       = 8;
	localparam logic [4:0] PATTERN_CYCLES  = 5'h04;
	localparam int         STATUS_WIP_BIT  = 0;
	localparam int         STATUS_WEL_BIT  = 1;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] PATTERN_RESET   = 8'h00;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ          = 100;
	localparam int GANG_TIME_NS     = 1000;
	localparam int GANG_CYCLES      = (GANG_TIME_NS * CLK_MHZ) / 1000;
	localparam int NV_PROG_TIME_NS  = 200000;
	localparam int NV_PROG_CYCLES   = (NV_PROG_TIME_NS * CLK_MHZ) / 1000;

	typedef enum logic [2:0] {
		ST_OPCODE,
		ST_SHIFT_OUT,
		ST_ADDR,
		ST_DUMMY,
		ST_PASS,
		ST_IGNORE
	} lpg_state_e;

endpackage

// ==== rtl/lpg_cmd.sv ====
// serial flash command interpreter for gang unprotect and the learning pattern.
// assumes the serial clock, chip select and io pins are asynchronous to clk_i
// and much slower (link clock at least 8 system clocks per period).

`timescale 1ns/1ps

module lpg_cmd #(
	parameter int GANG_CYCLES    = lpg_pkg::GANG_CYCLES,
	parameter int NV_PROG_CYCLES = lpg_pkg::NV_PROG_CYCLES
) (
	input  wire logic       clk_i,                           // system clock
	input  wire logic       reset_n_i,                       // async reset, low
	input  wire logic       sck_i,                           // serial clock pin
	input  wire logic       cs_n_i,                          // chip select pin, low
	input  wire logic [3:0] io_i,                            // io pins in
	output logic      [3:0] io_o,                            // io pins out
	output logic      [3:0] io_oe_o,                         // io drive enables
	input  wire logic       quad_command_mode_i,             // quad command mode
	input  wire logic       learning_pattern_enable_i,       // ext read bit 4
	input  wire logic [4:0] dummy_cycles_i,                  // selected dummy cycles
	input  wire logic       nv_program_fail_i,               // array program failed
	output logic            write_in_progress_o,             // status busy bit
	output logic            write_enable_latch_o,            // status latch bit
	output logic            program_error_o,                 // ext read error bit
	output logic            dynamic_sector_guard_set_all_o,  // set all guards pulse
	output logic      [7:0] nonvolatile_learning_pattern_o,  // nv pattern copy
	output logic      [7:0] volatile_learning_pattern_o,     // volatile pattern
	output logic            read_data_phase_o                // read data phase reached
);

	typedef struct packed {
		logic [2:0]          sck_s;
		logic [2:0]          cs_s;
		logic [2:0][3:0]     io_s;
		logic                sck_f;
		logic                cs_f;
		lpg_pkg::lpg_state_e st;
		logic [5:0]          bitcnt;
		logic [7:0]          shreg;
		logic [7:0]          opcode;
		logic [7:0]          clkcnt;
		logic [7:0]          addr_clks;
		logic [2:0]          idx;
		logic                pat_on;
		logic                write_enable_latch;
		logic                write_in_progress;
		logic                busy_nv;
		logic [31:0]         busy_cnt;
		logic [7:0]          nv;
		logic [7:0]          vol;
		logic [7:0]          pend;
		logic                perr;
		logic                dyb_pulse;
		logic [3:0]          io_out;
		logic [3:0]          io_oe;
		logic                data_phase;
	} lpg_state_s;

	lpg_state_s q;
	lpg_state_s d;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// clocks of address, plus mode bits on the dual and quad io reads, for the double rate reads
	function automatic logic [7:0] addr_clocks(input logic [7:0] op, input logic quad);
		logic [7:0] n;
		n = 8'h00;
		if (op == lpg_pkg::OP_FAST_READ_DR) begin
			n = quad ? 8'(lpg_pkg::ADDR_BITS / 8) : 8'(lpg_pkg::ADDR_BITS / 2);
		end else if (op == lpg_pkg::OP_FAST_READ_DUAL_IO_DR) begin
			n = 8'((lpg_pkg::ADDR_BITS + lpg_pkg::MODE_BITS) / 4);
		end else if (op == lpg_pkg::OP_FAST_READ_QUAD_IO_DR) begin
			n = 8'((lpg_pkg::ADDR_BITS + lpg_pkg::MODE_BITS) / 8);
		end
		return n;
	endfunction

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	logic       sck_new;
	logic       cs_new;
	logic       rise;
	logic       fall;
	logic       cs_rise;
	logic [5:0] nb;
	logic [7:0] nsh;
	logic [7:0] out_byte;
	logic [7:0] status;

	always_comb begin
		d = q;
		d.dyb_pulse = 1'b0;
		d.sck_s = {q.sck_s[1:0], sck_i};
		d.cs_s = {q.cs_s[1:0], cs_n_i};
		d.io_s = {q.io_s[1:0], io_i};
		// a change is taken once the second and third stages agree
		sck_new = (q.sck_s[2] == q.sck_s[1]) ? q.sck_s[2] : q.sck_f;
		cs_new = (q.cs_s[2] == q.cs_s[1]) ? q.cs_s[2] : q.cs_f;
		d.sck_f = sck_new;
		d.cs_f = cs_new;
		rise = sck_new & ~q.sck_f;
		fall = ~sck_new & q.sck_f;
		cs_rise = cs_new & ~q.cs_f;
		nb = quad_command_mode_i ? q.bitcnt + 6'h04 : q.bitcnt + 6'h01;
		nsh = quad_command_mode_i ? {q.shreg[3:0], q.io_s[2]} : {q.shreg[6:0], q.io_s[2][0]};
		status = 8'h00;
		status[lpg_pkg::STATUS_WIP_BIT] = q.write_in_progress;
		status[lpg_pkg::STATUS_WEL_BIT] = q.write_enable_latch;
		out_byte = (q.opcode == lpg_pkg::OP_READ_STATUS) ? status : q.vol;

		// self timed operations
		if (q.busy_cnt != 32'h0) begin
			d.busy_cnt = q.busy_cnt - 32'h1;
			if (q.busy_cnt == 32'h1) begin
				d.write_in_progress = 1'b0;
				d.write_enable_latch = 1'b0;
				if (q.busy_nv) begin
					d.nv = q.pend;
					d.perr = nv_program_fail_i;
				end
			end
		end

		if (cs_new) begin
			// commands execute only at deselect on an exact byte count
			if (cs_rise && !q.write_in_progress && q.st == lpg_pkg::ST_OPCODE) begin
				if (q.bitcnt == lpg_pkg::OPCODE_BITS) begin
					if (q.opcode == lpg_pkg::OP_WRITE_ENABLE_CMD) begin
						d.write_enable_latch = 1'b1;
					end else if (q.opcode == lpg_pkg::OP_GANG_UNPROTECT_CMD && q.write_enable_latch) begin
						d.dyb_pulse = 1'b1;
						d.write_in_progress = 1'b1;
						d.busy_nv = 1'b0;
						d.busy_cnt = 32'(GANG_CYCLES);
					end
				end else if (q.bitcnt == lpg_pkg::CMD_DATA_BITS && q.write_enable_latch) begin
					if (q.opcode == lpg_pkg::OP_PROGRAM_NV_PATTERN) begin
						d.pend = q.shreg;
						d.write_in_progress = 1'b1;
						d.busy_nv = 1'b1;
						d.perr = 1'b0;
						d.busy_cnt = 32'(NV_PROG_CYCLES);
					end else if (q.opcode == lpg_pkg::OP_WRITE_VOL_PATTERN) begin
						d.vol = q.shreg;
						d.write_enable_latch = 1'b0;
					end
				end
				// any other framing, or a clear latch, drops the command
			end
			d.st = lpg_pkg::ST_OPCODE;
			d.bitcnt = 6'h00;
			d.io_oe = 4'h0;
			d.pat_on = 1'b0;
			d.data_phase = 1'b0;
			d.clkcnt = 8'h00;
		end else if (rise) begin
			case (q.st)
				lpg_pkg::ST_OPCODE: begin
					d.shreg = nsh;
					if (q.bitcnt < lpg_pkg::BITCNT_CAP) begin
						d.bitcnt = nb;
					end
					if (nb == lpg_pkg::OPCODE_BITS) begin
						d.opcode = nsh;
						d.clkcnt = 8'h00;
						d.idx = 3'h7;
						d.addr_clks = addr_clocks(nsh, quad_command_mode_i);
						if (q.write_in_progress && nsh != lpg_pkg::OP_READ_STATUS) begin
							d.st = lpg_pkg::ST_IGNORE;
						end else if (nsh == lpg_pkg::OP_READ_STATUS ||
						             nsh == lpg_pkg::OP_READ_PATTERN_CMD) begin
							d.st = lpg_pkg::ST_SHIFT_OUT;
						end else if (nsh == lpg_pkg::OP_FAST_READ_DR ||
						             nsh == lpg_pkg::OP_FAST_READ_QUAD_IO_DR ||
						             (nsh == lpg_pkg::OP_FAST_READ_DUAL_IO_DR &&
						              !quad_command_mode_i)) begin
							d.st = lpg_pkg::ST_ADDR;
						end else if (nsh != lpg_pkg::OP_WRITE_ENABLE_CMD &&
						             nsh != lpg_pkg::OP_GANG_UNPROTECT_CMD &&
						             nsh != lpg_pkg::OP_PROGRAM_NV_PATTERN &&
						             nsh != lpg_pkg::OP_WRITE_VOL_PATTERN) begin
							d.st = lpg_pkg::ST_IGNORE;
						end
					end
				end
				lpg_pkg::ST_ADDR: begin
					d.clkcnt = q.clkcnt + 8'h01;
					if (q.clkcnt + 8'h01 == q.addr_clks) begin
						d.st = lpg_pkg::ST_DUMMY;
						d.clkcnt = 8'h00;
					end
				end
				lpg_pkg::ST_DUMMY: begin
					if (q.clkcnt == {3'h0, dummy_cycles_i}) begin
						// pattern done, the read data path takes the pins
						d.st = lpg_pkg::ST_PASS;
						d.pat_on = 1'b0;
						d.io_oe = 4'h0;
						d.data_phase = 1'b1;
					end else begin
						d.clkcnt = q.clkcnt + 8'h01;
						if (learning_pattern_enable_i && dummy_cycles_i >= lpg_pkg::PATTERN_CYCLES &&
						    q.clkcnt == {3'h0, dummy_cycles_i - lpg_pkg::PATTERN_CYCLES}) begin
							d.pat_on = 1'b1;
							d.io_out = {4{q.vol[7]}};
							d.io_oe = 4'hF;
							d.idx = 3'h6;
						end else if (q.pat_on) begin
							d.io_out = {4{q.vol[q.idx]}};
							d.idx = q.idx - 3'h1;
						end
					end
				end
				default: begin
				end
			endcase
		end else if (fall) begin
			case (q.st)
				lpg_pkg::ST_SHIFT_OUT: begin
					// repeats the byte because idx wraps; status is resampled on every falling edge
					if (quad_command_mode_i) begin
						d.io_out = (q.idx == 3'h7) ? out_byte[7:4] : out_byte[3:0];
						d.io_oe = 4'hF;
						d.idx = q.idx - 3'h4;
					end else begin
						d.io_out = {2'h0, out_byte[q.idx], 1'b0};
						d.io_oe = 4'h2;
						d.idx = q.idx - 3'h1;
					end
				end
				lpg_pkg::ST_DUMMY: begin
					if (q.pat_on) begin
						d.io_out = {4{q.vol[q.idx]}};
						d.idx = q.idx - 3'h1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q <= '0;
			q.sck_s <= 3'h0;
			q.cs_s <= 3'h7;
			q.cs_f <= 1'b1;
			q.st <= lpg_pkg::ST_OPCODE;
			q.nv <= lpg_pkg::PATTERN_RESET;
			q.vol <= lpg_pkg::PATTERN_RESET;
			q.pend <= lpg_pkg::PATTERN_RESET;
		end else begin
			q <= d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign io_o = q.io_out;
	assign io_oe_o = q.io_oe;
	assign write_in_progress_o = q.write_in_progress;
	assign write_enable_latch_o = q.write_enable_latch;
	assign program_error_o = q.perr;
	assign dynamic_sector_guard_set_all_o = q.dyb_pulse;
	assign nonvolatile_learning_pattern_o = q.nv;
	assign volatile_learning_pattern_o = q.vol;
	assign read_data_phase_o = q.data_phase;

endmodule

// ==== verification/lpg_cmd_asserts.sv ====
// port checker for the flash command interpreter.
// assumes it is bound to lpg_cmd; everything lives in the clk_i domain.
`timescale 1ns/1ps
module lpg_cmd_asserts #(
	parameter int GANG_CYCLES    = 100,
	parameter int NV_PROG_CYCLES = 20000
) (
	input wire logic       clk_i,                          // clock
	input wire logic       reset_n_i,                      // reset
	input wire logic       sck_i,                          // link clock
	input wire logic       cs_n_i,                         // select
	input wire logic [3:0] io_i,                           // io in
	input wire logic [3:0] io_o,                           // io out
	input wire logic [3:0] io_oe_o,                        // io enable
	input wire logic       quad_command_mode_i,            // quad
	input wire logic       learning_pattern_enable_i,      // enable
	input wire logic [4:0] dummy_cycles_i,                 // dummy
	input wire logic       nv_program_fail_i,              // fail
	input wire logic       write_in_progress_o,            // busy
	input wire logic       write_enable_latch_o,           // latch
	input wire logic       program_error_o,                // error
	input wire logic       dynamic_sector_guard_set_all_o, // pulse
	input wire logic [7:0] nonvolatile_learning_pattern_o, // nv
	input wire logic [7:0] volatile_learning_pattern_o,    // vol
	input wire logic       read_data_phase_o               // data
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// slack covers the link synchroniser delay
	localparam int BUSY_MAX = (GANG_CYCLES > NV_PROG_CYCLES ? GANG_CYCLES : NV_PROG_CYCLES) + 8;
	logic [31:0] busy_q;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_q <= 32'h0;
		end else begin
			busy_q <= write_in_progress_o ? busy_q + 32'h1 : 32'h0;
		end
	end
	sequence gang_start;
		dynamic_sector_guard_set_all_o && write_enable_latch_o;
	endsequence
	sequence gang_busy;
		##[0:1] write_in_progress_o;
	endsequence
	a_gang_needs_latch: assert property (dynamic_sector_guard_set_all_o |-> gang_start)
		else $error("guard pulse without latch");
	a_gang_sets_busy: assert property (gang_start |-> gang_busy ##1 !dynamic_sector_guard_set_all_o)
		else $error("guard pulse not single or not busy");
	a_busy_bounded: assert property (busy_q <= BUSY_MAX)
		else $error("busy too long");
	a_done_clears_latch: assert property ($fell(write_in_progress_o) |-> !write_enable_latch_o)
		else $error("latch left set after busy");
	a_nv_at_done: assert property (($changed(nonvolatile_learning_pattern_o) || $rose(program_error_o)) |-> $fell(write_in_progress_o))
		else $error("nv copy or error outside completion");
	a_vol_needs_latch: assert property ($changed(volatile_learning_pattern_o) |-> $past(write_enable_latch_o))
		else $error("volatile written without latch");
	a_pattern_same_lines: assert property (io_oe_o == 4'hF && !quad_command_mode_i |-> io_o == 4'h0 || io_o == 4'hF)
		else $error("pattern differs across lines");
	a_pattern_off: assert property (!learning_pattern_enable_i && !quad_command_mode_i |-> io_oe_o != 4'hF)
		else $error("pattern driven while disabled");
	a_phase_lines_free: assert property (read_data_phase_o |-> io_oe_o == 4'h0)
		else $error("pins driven in read data phase");
endmodule
bind lpg_cmd lpg_cmd_asserts #(.GANG_CYCLES(GANG_CYCLES), .NV_PROG_CYCLES(NV_PROG_CYCLES)) lpg_cmd_asserts_inst (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .io_i(io_i),
	.io_o(io_o), .io_oe_o(io_oe_o), .quad_command_mode_i(quad_command_mode_i),
	.learning_pattern_enable_i(learning_pattern_enable_i), .dummy_cycles_i(dummy_cycles_i),
	.nv_program_fail_i(nv_program_fail_i), .write_in_progress_o(write_in_progress_o),
	.write_enable_latch_o(write_enable_latch_o), .program_error_o(program_error_o),
	.dynamic_sector_guard_set_all_o(dynamic_sector_guard_set_all_o),
	.nonvolatile_learning_pattern_o(nonvolatile_learning_pattern_o),
	.volatile_learning_pattern_o(volatile_learning_pattern_o),
	.read_data_phase_o(read_data_phase_o));

// ==== verification/lpg_host.sv ====
// host flash controller model: mode 0 link clock, 13 system clocks a period.
// assumes io_i is the resolved wire; released lines show the inverse value.
`timescale 1ns/1ps
module lpg_host (
	input  wire logic       clk_i,  // system clock
	input  wire logic [3:0] io_i,   // resolved io
	output logic            sck_o,  // link clock
	output logic            cs_n_o, // select, low
	output logic      [3:0] io_o    // host io value
);
	logic [3:0] cap [0:63];
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		io_o = 4'h0;
	end
	task automatic xfer(input logic [31:0] dat, input int nd, input int nt, input logic quad);
		@(posedge clk_i) cs_n_o <= 1'b0;
		for (int i = 0; i < nt; i++) begin
			if (i >= nd) io_o <= ~io_o;
			else if (quad) io_o <= dat[31-4*i -: 4];
			else io_o <= {~io_o[3:1], dat[31-i]};
			repeat (6) @(posedge clk_i);
			cap[2*i] = io_i;
			sck_o <= 1'b1;
			repeat (7) @(posedge clk_i);
			cap[2*i+1] = io_i;
			sck_o <= 1'b0;
		end
		// deselect only after a full low phase so the last bit is not cut
		repeat (6) @(posedge clk_i);
		cs_n_o <= 1'b1;
		io_o <= ~io_o;
		repeat (8) @(posedge clk_i);
	endtask
endmodule

// ==== verification/lpg_cmd_bench.sv ====
// bench for the command interpreter, driven through the host model.
// assumes short busy counts; link answers are judged from captured io.
`timescale 1ns/1ps
module lpg_cmd_bench;
	localparam logic [7:0] PAT = 8'h34;
	logic       clk_i = 1'b0;
	logic       reset_n_i = 1'b0;
	logic       quad = 1'b0;
	logic       pen = 1'b0;
	logic [4:0] dummy = 5'h05;
	logic       fail = 1'b0;
	logic       sck, cs_n, write_in_progress, write_enable_latch, perr, pulse, rdp;
	logic [3:0] hio, dio, doe, io_w;
	logic [7:0] nv, vol;
	int         failures = 0;
	int         compares = 0;
	int         npulse = 0;
	int         nfull = 0;
	int         nphase = 0;
	assign io_w = (doe & dio) | (~doe & hio);
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		npulse <= npulse + int'(pulse);
		nfull <= nfull + int'(doe == 4'hF);
		nphase <= nphase + int'(rdp);
	end
	lpg_cmd #(.GANG_CYCLES(400), .NV_PROG_CYCLES(300)) lpg_cmd_inst (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .sck_i(sck), .cs_n_i(cs_n), .io_i(io_w),
		.io_o(dio), .io_oe_o(doe), .quad_command_mode_i(quad), .learning_pattern_enable_i(pen),
		.dummy_cycles_i(dummy), .nv_program_fail_i(fail), .write_in_progress_o(write_in_progress),
		.write_enable_latch_o(write_enable_latch), .program_error_o(perr), .dynamic_sector_guard_set_all_o(pulse),
		.nonvolatile_learning_pattern_o(nv), .volatile_learning_pattern_o(vol),
		.read_data_phase_o(rdp));
	lpg_host lpg_host_inst (.clk_i(clk_i), .io_i(io_w), .sck_o(sck), .cs_n_o(cs_n), .io_o(hio));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		if (failures == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic cmd(input logic [31:0] dat, input int nd, input int nt);
		lpg_host_inst.xfer(dat, nd, nt, quad);
	endtask
	task automatic write_enable_cmd();
		cmd(32'h06000000, quad ? 2 : 8, quad ? 2 : 8);
	endtask
	function automatic logic [7:0] rd_byte(input int base);
		rd_byte = {lpg_host_inst.cap[base], lpg_host_inst.cap[base+2]};
		for (int b = 0; b < 8; b++) if (!quad) rd_byte[b] = lpg_host_inst.cap[base+14-2*b][1];
	endfunction
	task automatic wait_idle();
		for (int i = 0; i < 2000; i++) begin
			@(posedge clk_i);
			if (write_in_progress === 1'b0) return;
		end
		failures++;
		final_report();
	endtask
	task automatic t_gang();
		cmd(32'h98000000, 8, 8);
		check("pulse", 8'(npulse), 8'h00);
		write_enable_cmd();
		cmd(32'h98000000, 9, 9);
		check("pulse", 8'(npulse), 8'h00);
		cmd(32'h98000000, 8, 8);
		check("pulse", 8'(npulse), 8'h01);
		cmd(32'h05000000, 8, 16);
		check("status", rd_byte(16), 8'h03);
		wait_idle();
		check("status", {6'h0, write_enable_latch, write_in_progress}, 8'h00);
		quad <= 1'b1;
		@(posedge clk_i);
		write_enable_cmd();
		cmd(32'h98000000, 2, 2);
		check("pulse", 8'(npulse), 8'h02);
		wait_idle();
	endtask
	task automatic t_pat();
		write_enable_cmd();
		cmd({8'h4A, PAT, 16'h0}, 4, 4);
		check("volatile", vol, PAT);
		cmd(32'h4A550000, 4, 4);
		check("volatile", vol, PAT);
		cmd(32'h41000000, 2, 6);
		check("readback", rd_byte(8), PAT);
		quad <= 1'b0;
		fail <= 1'b1;
		@(posedge clk_i);
		write_enable_cmd();
		cmd(32'h43A50000, 16, 16);
		check("status", {6'h0, write_enable_latch, write_in_progress}, 8'h03);
		wait_idle();
		check("nonvolatile", nv, 8'hA5);
		check("status", {5'h0, perr, write_enable_latch, write_in_progress}, 8'h04);
		cmd(32'h41000000, 8, 24);
		check("readback", rd_byte(32), PAT);
		// a clean program must leave the error bit low again
		fail <= 1'b0;
		write_enable_cmd();
		cmd(32'h435A0000, 16, 16);
		wait_idle();
		check("nonvolatile", nv, 8'h5A);
		check("status", {5'h0, perr, write_enable_latch, write_in_progress}, 8'h00);
	endtask
	task automatic t_dlp();
		// entry: quad flag, opcode, address clocks
		logic [15:0] tab [5] = '{16'h00DC, 16'h10D3, 16'h0BD8, 16'h0ED4, 16'h1ED4};
		int oc, ad, k, ph;
		pen <= 1'b1;
		// the pattern needs at least 4 dummy clocks; 6 leaves two clocks before it
		dummy <= 5'h06;
		foreach (tab[t]) begin
			quad <= tab[t][12];
			@(posedge clk_i);
			oc = tab[t][12] ? 2 : 8;
			ad = int'(tab[t][3:0]);
			ph = nphase;
			cmd({tab[t][11:4], 24'h0}, oc + ad, oc + ad + int'(dummy) + 1);
			// data phase spans the host's last high and low phases: 7 plus 6 clocks
			check("data phase", 8'(nphase - ph), 8'h0D);
			for (int m = 0; m < 8; m++) begin
				k = 2 * (oc + ad + int'(dummy) - 4) + 1 + m;
				check("pattern", {4'h0, lpg_host_inst.cap[k]}, {4'h0, {4{PAT[7-m]}}});
			end
		end
		pen <= 1'b0;
		quad <= 1'b0;
		@(posedge clk_i);
		k = nfull;
		ph = nphase;
		cmd(32'h0D000000, 20, 27);
		check("drive", 8'(nfull - k), 8'h00);
		check("data phase", 8'(nphase - ph), 8'h0D);
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		t_gang();
		t_pat();
		t_dlp();
		final_report();
	end
endmodule
